/* core/timing_pkg.sv */
// Constants, types and carriers shared by the per-class instruction timing block.
// Assumes one core clock and one asynchronous active-low reset around its users.
//
// Overview of operation
// - Memory stall cycles lengthen the quoted counts of load, store, event load, jump, fence and branch instructions.
// - Integer computational instructions complete in one cycle.
// - Plain multiply uses single-cycle lower-word multiplier.
// - Upper-word multiplies take five cycles.
// - Divide time follows divisor leading zero count.
// - Divisor without leading zeros takes three cycles.
// - Zero divisor takes thirty-five cycles.
// - Aligned access: one transaction, one cycle.
// - Split access: two transactions, two cycles.
// - Event load word takes four cycles.
// - Jump in decode flushes fetch; two/three cycles.
// - Jump target fetch issued during decode cycle.
// - Untaken branch costs one cycle, no stall.
// - Taken branch decided in execute; three/four cycles.
// - Taken branch flushes fetch and decode.
// - Listed machine/debug CSRs four cycles, others one.
// - Instruction fence is jump to next instruction.
// - Floating point costs its latency plus one.
// - Independent integer work continues past floating point.
// - Enough independent instructions hide floating-point latency.
// - Load result used next costs one stall.

package timing_pkg;

   // ----------------
   // Widths
   // ----------------
   localparam int CNT_W = 8;
   localparam int XLEN  = 32;

   typedef logic [CNT_W-1:0] count_type;

   // ----------------
   // Cycle counts per instruction class, and the fence's next-instruction address step
   // ----------------
   localparam count_type CYC_SINGLE       = 8'h01;
   localparam count_type CYC_MULH         = 8'h05;
   localparam count_type CYC_DIV_MIN      = 8'h03;
   localparam count_type CYC_SPLIT        = 8'h02;
   localparam count_type CYC_ELW          = 8'h04;
   localparam count_type CYC_JUMP         = 8'h02;
   localparam count_type CYC_BRANCH_TAKEN = 8'h03;
   localparam count_type CYC_CSR_SLOW     = 8'h04;
   localparam count_type CYC_UNALIGNED    = 8'h01;
   localparam count_type CYC_LOAD_USE     = 8'h01;
   localparam count_type FP_DIVSQRT_WAIT  = 8'h0b;
   localparam logic [31:0] NEXT_INSN_STEP = 32'h0000_0004;

   // ----------------
   // Machine and debug CSR addresses that take the slow path
   // ----------------
   localparam logic [11:0] CSR_MSTATUS       = 12'h300;
   localparam logic [11:0] CSR_MTVEC         = 12'h305;
   localparam logic [11:0] CSR_MCOUNTINHIBIT = 12'h320;
   localparam logic [11:0] CSR_MHPMEVENT_LO  = 12'h323;
   localparam logic [11:0] CSR_MHPMEVENT_HI  = 12'h33f;
   localparam logic [11:0] CSR_MEPC          = 12'h341;
   localparam logic [11:0] CSR_MCAUSE        = 12'h342;
   localparam logic [11:0] CSR_DCSR          = 12'h7b0;
   localparam logic [11:0] CSR_DSCRATCH1     = 12'h7b3;
   localparam logic [11:0] CSR_MCOUNTER_LO   = 12'hb00;
   localparam logic [11:0] CSR_MCOUNTER_HI   = 12'hb1f;
   localparam logic [11:0] CSR_MCOUNTERH_LO  = 12'hb80;
   localparam logic [11:0] CSR_MCOUNTERH_HI  = 12'hb9f;

   // ----------------
   // Enumerations
   // ----------------
   typedef enum logic [3:0] {
      IC_INT, IC_MUL, IC_MULH, IC_DIV, IC_LOAD, IC_STORE, IC_ELW,
      IC_JUMP, IC_BRANCH, IC_CSR, IC_FENCE_I, IC_FP
   } iclass_type;

   typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} mem_size_type;
   typedef enum logic [1:0] {FP_ADDMUL, FP_MISC, FP_DIVSQRT} fp_kind_type;
   typedef enum logic {PH_IDLE, PH_RUN} phase_type;

   // ----------------
   // Carriers
   // ----------------
   typedef struct packed {
      iclass_type   iclass;
      logic [31:0]  pc;
      logic [31:0]  target;
      logic         target_unaligned;
      logic         taken;
      logic [31:0]  divisor;
      logic [1:0]   addr_lo;
      mem_size_type size;
      logic [11:0]  csr_addr;
      fp_kind_type  fp_kind;
      logic [4:0]   rd;
      logic [4:0]   rs1;
      logic [4:0]   rs2;
      logic [4:0]   rs3;
   } issue_type;

   typedef struct packed {
      logic        ready;
      logic        done;
      logic        ex_busy;
      logic        flush_if;
      logic        flush_id;
      logic        fetch_req;
      logic [31:0] fetch_addr;
      logic        bus_txn;
      logic        fp_dispatch;
      logic        fp_busy;
   } status_type;

   typedef struct packed {
      phase_type  phase;
      count_type  remaining;
      iclass_type cur;
      logic       second_txn;
      count_type  fp_remaining;
      logic [4:0] fp_rd;
      logic       load_pending;
      logic [4:0] load_rd;
      status_type out;
   } state_type;

   localparam logic RESET_READY = 1'b1;

endpackage : timing_pkg

/* core/leading_zero_count.sv */
// Leading zero counter for the divisor operand.
// Purely combinational; the caller registers whatever it derives from it.

`timescale 1ns/1ps

module leading_zero_count #(
   parameter int WIDTH = 32
) (
   // Operand in
   input  wire logic [WIDTH-1:0]         value_i,
   // Count out, WIDTH when the operand is zero
   output logic      [$clog2(WIDTH+1)-1:0] zeros_o
);

   // ----------------------------------------------------------------
   // Scan from the top bit
   // ----------------------------------------------------------------

   // The first set bit found from the top stops the count.
   always_comb begin
      logic found;
      found   = 1'b0;
      zeros_o = '0;
      for (int i = WIDTH - 1; i >= 0; i--) begin
         if (!found && value_i[i]) begin
            found   = 1'b1;
            zeros_o = ($clog2(WIDTH+1))'(WIDTH - 1 - i);
         end
      end
      if (!found) begin
         zeros_o = ($clog2(WIDTH+1))'(WIDTH);
      end
   end

endmodule // leading_zero_count

/* core/instr_cycle_timing.sv */
// Per-class cycle timing of a four-stage in-order pipeline: occupancy of
// execute, fetch and decode flushes, redirect requests, bus transaction
// counting, and outstanding floating-point tracking.
// Assumes a decoder that presents one classified instruction at a time on
// the same clock, and memory stall flags from the bus interfaces.

`timescale 1ns/1ps

module instr_cycle_timing #(
   parameter int unsigned fp_add_multiply_latency = 0,
   parameter int unsigned fp_misc_op_latency      = 0
) (
   // Clock and reset
   input  wire logic                   mclk_i,
   input  wire logic                   arst_n_i,
   // Instruction issue from decode
   input  wire logic                   issue_valid_i,
   input  wire timing_pkg::issue_type  issue_i,
   // Memory interface wait indications
   input  wire logic                   instr_stall_i,
   input  wire logic                   data_stall_i,
   // Pipeline control and status
   output timing_pkg::status_type      status_o
);

   // ----------------
   // Decoding helpers
   // ----------------

   // True for the CSRs that go through the slow, four-cycle path.
   function automatic logic csr_is_slow(input logic [11:0] addr);
      logic slow;
      slow = (addr == timing_pkg::CSR_MSTATUS) || (addr == timing_pkg::CSR_MTVEC) ||
             (addr == timing_pkg::CSR_MEPC) || (addr == timing_pkg::CSR_MCAUSE) ||
             (addr == timing_pkg::CSR_MCOUNTINHIBIT) ||
             (addr >= timing_pkg::CSR_MHPMEVENT_LO && addr <= timing_pkg::CSR_MHPMEVENT_HI) ||
             (addr >= timing_pkg::CSR_DCSR && addr <= timing_pkg::CSR_DSCRATCH1) ||
             (addr >= timing_pkg::CSR_MCOUNTER_LO && addr <= timing_pkg::CSR_MCOUNTER_HI) ||
             (addr >= timing_pkg::CSR_MCOUNTERH_LO && addr <= timing_pkg::CSR_MCOUNTERH_HI);
      return slow;
   endfunction

   // True when the instruction reads or writes the given register.
   function automatic logic touches_reg(input timing_pkg::issue_type insn, input logic [4:0] r);
      return (insn.rs1 == r) || (insn.rs2 == r) || (insn.rs3 == r) || (insn.rd == r);
   endfunction

   // True when a stall on the matching memory interface holds this class.
   function automatic logic held_by_memory(input timing_pkg::iclass_type cls, input logic istall,
                                           input logic dstall);
      logic held;
      held = 1'b0;
      unique case (cls)
         timing_pkg::IC_LOAD, timing_pkg::IC_STORE, timing_pkg::IC_ELW: held = dstall;
         timing_pkg::IC_JUMP, timing_pkg::IC_FENCE_I, timing_pkg::IC_BRANCH: held = istall;
         default: held = 1'b0;
      endcase
      return held;
   endfunction

   // ----------------
   // State
   // ----------------
   timing_pkg::state_type  st;
   timing_pkg::state_type  next_st;

   logic [5:0]             div_zeros;
   timing_pkg::count_type  base_cost;
   timing_pkg::count_type  fp_wait;
   logic                   split_access;
   logic                   redirect;
   logic                   fp_hazard;
   logic                   load_use;

   // ----------------
   // Divisor leading zeros
   // ----------------
   leading_zero_count #(
      .WIDTH   (timing_pkg::XLEN)
   ) u_div_lzc (
      .value_i (issue_i.divisor),
      .zeros_o (div_zeros)
   );

   // ----------------
   // Cost of the presented instruction
   // ----------------

   // Base occupancy before hazards, as if neither memory interface waits.
   always_comb begin
      split_access = ((issue_i.size == timing_pkg::SZ_WORD) && (issue_i.addr_lo != 2'h0)) ||
                     ((issue_i.size == timing_pkg::SZ_HALF) && (issue_i.addr_lo == 2'h3));
      redirect     = 1'b0;
      base_cost    = timing_pkg::CYC_SINGLE;
      unique case (issue_i.iclass)
         timing_pkg::IC_INT: base_cost = timing_pkg::CYC_SINGLE;
         timing_pkg::IC_MUL: base_cost = timing_pkg::CYC_SINGLE;
         timing_pkg::IC_MULH: base_cost = timing_pkg::CYC_MULH;
         // divisor-driven length; gives 3 at no zeros, gives 35 at zero.
         timing_pkg::IC_DIV: base_cost = timing_pkg::CYC_DIV_MIN + timing_pkg::count_type'(div_zeros);
         timing_pkg::IC_LOAD, timing_pkg::IC_STORE: begin
            base_cost = split_access ? timing_pkg::CYC_SPLIT : timing_pkg::CYC_SINGLE;
         end
         timing_pkg::IC_ELW: base_cost = timing_pkg::CYC_ELW;
         // jump resolved in decode; fence reuses the jump path.
         timing_pkg::IC_JUMP, timing_pkg::IC_FENCE_I: begin
            redirect  = 1'b1;
            base_cost = timing_pkg::CYC_JUMP +
                        (issue_i.target_unaligned ? timing_pkg::CYC_UNALIGNED : '0);
         end
         // untaken branch; taken branch from execute.
         timing_pkg::IC_BRANCH: begin
            redirect  = issue_i.taken;
            base_cost = !issue_i.taken ? timing_pkg::CYC_SINGLE :
                        timing_pkg::CYC_BRANCH_TAKEN +
                        (issue_i.target_unaligned ? timing_pkg::CYC_UNALIGNED : '0);
         end
         timing_pkg::IC_CSR: begin
            base_cost = csr_is_slow(issue_i.csr_addr) ? timing_pkg::CYC_CSR_SLOW : timing_pkg::CYC_SINGLE;
         end
         // dispatch takes one core cycle; the unit keeps the rest.
         timing_pkg::IC_FP: base_cost = timing_pkg::CYC_SINGLE;
      endcase
   end

   // Latency the floating-point unit keeps after its dispatch cycle.
   always_comb begin
      unique case (issue_i.fp_kind)
         timing_pkg::FP_ADDMUL:  fp_wait = timing_pkg::count_type'(fp_add_multiply_latency);
         timing_pkg::FP_MISC:    fp_wait = timing_pkg::count_type'(fp_misc_op_latency);
         timing_pkg::FP_DIVSQRT: fp_wait = timing_pkg::FP_DIVSQRT_WAIT;
         default:                fp_wait = timing_pkg::FP_DIVSQRT_WAIT;
      endcase
   end

   // Hazards against work still in flight.
   always_comb begin
      // only dependent or floating-point followers wait.
      fp_hazard = (st.fp_remaining != '0) &&
                  ((issue_i.iclass == timing_pkg::IC_FP) || touches_reg(issue_i, st.fp_rd));
      // consumer of the load just before.
      load_use  = st.load_pending && ((issue_i.rs1 == st.load_rd) || (issue_i.rs2 == st.load_rd) ||
                                      (issue_i.rs3 == st.load_rd));
   end

   // ----------------
   // Next state
   // ----------------

   // Pulses fall back every cycle; a multi-cycle instruction holds ready low
   // until its last cycle, so the decoder never needs a combinational stall.
   always_comb begin
      timing_pkg::count_type cost;
      logic                  held;
      cost    = '0;
      held    = 1'b0;
      next_st = st;
      next_st.out.done        = 1'b0;
      next_st.out.flush_if    = 1'b0;
      next_st.out.flush_id    = 1'b0;
      next_st.out.fetch_req   = 1'b0;
      next_st.out.bus_txn     = 1'b0;
      next_st.out.fp_dispatch = 1'b0;

      // the outstanding latency drains one per cycle, independent work hides it.
      if (st.fp_remaining != '0) begin
         next_st.fp_remaining = st.fp_remaining - timing_pkg::count_type'(1);
      end

      unique case (st.phase)
         timing_pkg::PH_IDLE: begin
            if (issue_valid_i && st.out.ready) begin
               // one extra cycle after a load feeding this one.
               cost = base_cost + (load_use ? timing_pkg::CYC_LOAD_USE : '0);
               // a dependent waits out what is left of the latency.
               if (fp_hazard) begin
                  cost = cost + st.fp_remaining;
               end
               // a waiting memory interface freezes the count.
               held = held_by_memory(issue_i.iclass, instr_stall_i, data_stall_i);
               next_st.cur          = issue_i.iclass;
               next_st.load_pending = (issue_i.iclass == timing_pkg::IC_LOAD) && (issue_i.rd != 5'h00);
               next_st.load_rd      = issue_i.rd;
               // first bus transaction; queues the second.
               next_st.out.bus_txn  = (issue_i.iclass == timing_pkg::IC_LOAD) ||
                                      (issue_i.iclass == timing_pkg::IC_STORE) ||
                                      (issue_i.iclass == timing_pkg::IC_ELW);
               next_st.second_txn   = split_access &&
                                      ((issue_i.iclass == timing_pkg::IC_LOAD) ||
                                       (issue_i.iclass == timing_pkg::IC_STORE));
               if (redirect) begin
                  // fetch stage and prefetch buffer discarded.
                  next_st.out.flush_if  = 1'b1;
                  next_st.out.flush_id  = (issue_i.iclass == timing_pkg::IC_BRANCH);
                  // target request issued with the redirect.
                  next_st.out.fetch_req = 1'b1;
                  // fence redirects to the following instruction.
                  next_st.out.fetch_addr = (issue_i.iclass == timing_pkg::IC_FENCE_I) ?
                                           issue_i.pc + timing_pkg::NEXT_INSN_STEP : issue_i.target;
               end
               if (issue_i.iclass == timing_pkg::IC_FP) begin
                  // dispatched; the unit owns the rest of the latency.
                  next_st.out.fp_dispatch = 1'b1;
                  next_st.fp_remaining    = fp_wait + cost - timing_pkg::CYC_SINGLE;
                  next_st.fp_rd           = issue_i.rd;
               end
               if ((cost == timing_pkg::CYC_SINGLE) && !held) begin
                  next_st.out.done = 1'b1;
               end else begin
                  next_st.phase       = timing_pkg::PH_RUN;
                  next_st.remaining   = held ? cost : cost - timing_pkg::CYC_SINGLE;
                  next_st.out.ready   = 1'b0;
                  next_st.out.ex_busy = 1'b1;
               end
            end
         end
         timing_pkg::PH_RUN: begin
            // second half of a split access follows the first.
            if (st.second_txn) begin
               next_st.out.bus_txn = 1'b1;
               next_st.second_txn  = 1'b0;
            end
            // no progress while the relevant interface waits.
            held = held_by_memory(st.cur, instr_stall_i, data_stall_i);
            if (!held) begin
               next_st.remaining = st.remaining - timing_pkg::count_type'(1);
               if (st.remaining == timing_pkg::CYC_SINGLE) begin
                  next_st.phase       = timing_pkg::PH_IDLE;
                  next_st.out.done    = 1'b1;
                  next_st.out.ready   = 1'b1;
                  next_st.out.ex_busy = 1'b0;
               end
            end
         end
      endcase

      next_st.out.fp_busy = (next_st.fp_remaining != '0);
   end

   // ----------------
   // State register
   // ----------------

   // The whole state lives in one register so every output is a flop.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st           <= '0;
         st.out.ready <= timing_pkg::RESET_READY;
      end else begin
         st <= next_st;
      end
   end

   assign status_o = st.out;

endmodule // instr_cycle_timing

/* dv/instr_cycle_timing_checker.sv */
// Concurrent checks on the per-class timing block, seen from its ports.
// Assumes one clock and the asynchronous active-low reset of the block.
`timescale 1ns/1ps
module instr_cycle_timing_checker #(
   parameter int unsigned fp_add_multiply_latency = 0,
   parameter int unsigned fp_misc_op_latency      = 0
) (
   // Clock and reset
   input wire logic                  mclk_i,
   input wire logic                  arst_n_i,
   // Watched ports
   input wire logic                  issue_valid_i,
   input wire timing_pkg::issue_type issue_i,
   input wire logic                  instr_stall_i,
   input wire logic                  data_stall_i,
   input wire timing_pkg::status_type status_o
);
   // ----------------------------------------------------------------
   // Helpers: a take, and a take free of operand hazards.
   // ----------------------------------------------------------------
   wire take = issue_valid_i & status_o.ready;
   wire ok   = take & ~status_o.fp_busy & (issue_i.rs1 == 5'h0) & (issue_i.rs2 == 5'h0) & (issue_i.rs3 == 5'h0);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   property p_single;
      ok && (issue_i.iclass == timing_pkg::IC_INT || issue_i.iclass == timing_pkg::IC_MUL) |=> status_o.done;
   endproperty
   a_single: assert property (p_single) else $error("single-cycle class late");
   property p_mulh;
      ok && issue_i.iclass == timing_pkg::IC_MULH |=> !status_o.done [*4] ##1 status_o.done;
   endproperty
   a_mulh: assert property (p_mulh) else $error("upper multiply not five cycles");
   property p_div_min;
      ok && issue_i.iclass == timing_pkg::IC_DIV && issue_i.divisor[31] |=> !status_o.done [*2] ##1 status_o.done;
   endproperty
   a_div_min: assert property (p_div_min) else $error("divide minimum wrong");
   property p_div_zero;
      ok && issue_i.iclass == timing_pkg::IC_DIV && issue_i.divisor == 32'h0000_0000 |-> ##35 status_o.done;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("zero divisor not 35 cycles");
   property p_split;
      take && issue_i.iclass == timing_pkg::IC_STORE && issue_i.size == timing_pkg::SZ_WORD
      && issue_i.addr_lo != 2'h0 && !data_stall_i |=> status_o.bus_txn ##1 status_o.bus_txn;
   endproperty
   a_split: assert property (p_split) else $error("split access lacks two transactions");
   property p_jump;
      take && issue_i.iclass == timing_pkg::IC_JUMP |=> status_o.flush_if && status_o.fetch_req
      && !status_o.flush_id && status_o.fetch_addr == $past(issue_i.target);
   endproperty
   a_jump: assert property (p_jump) else $error("jump redirect wrong");
   property p_taken;
      take && issue_i.iclass == timing_pkg::IC_BRANCH && issue_i.taken |=> status_o.flush_if && status_o.flush_id;
   endproperty
   a_taken: assert property (p_taken) else $error("taken branch flush missing");
   property p_not_taken;
      ok && issue_i.iclass == timing_pkg::IC_BRANCH && !issue_i.taken && !instr_stall_i
      |=> status_o.done && !status_o.flush_if;
   endproperty
   a_not_taken: assert property (p_not_taken) else $error("untaken branch stalled");
   property p_csr;
      ok && issue_i.iclass == timing_pkg::IC_CSR && issue_i.csr_addr == 12'h300 |=> !status_o.done [*3] ##1 status_o.done;
   endproperty
   a_csr: assert property (p_csr) else $error("slow register access not four cycles");
   property p_fence;
      take && issue_i.iclass == timing_pkg::IC_FENCE_I |=> status_o.fetch_req
      && status_o.fetch_addr == $past(issue_i.pc) + 32'h0000_0004;
   endproperty
   a_fence: assert property (p_fence) else $error("fence redirect wrong");
   property p_busy;
      status_o.ex_busy |-> !status_o.ready && !status_o.done;
   endproperty
   a_busy: assert property (p_busy) else $error("busy while ready");
   c_div: cover property (take && issue_i.iclass == timing_pkg::IC_DIV);
   c_jump: cover property (status_o.flush_if && status_o.fetch_req);
   c_fp: cover property (status_o.fp_dispatch);
endmodule // instr_cycle_timing_checker

bind instr_cycle_timing instr_cycle_timing_checker #(
   .fp_add_multiply_latency(fp_add_multiply_latency),
   .fp_misc_op_latency     (fp_misc_op_latency)
) i_instr_cycle_timing_checker (
   .mclk_i(mclk_i), .arst_n_i(arst_n_i), .issue_valid_i(issue_valid_i), .issue_i(issue_i),
   .instr_stall_i(instr_stall_i), .data_stall_i(data_stall_i), .status_o(status_o)
);

/* dv/mem_stall_model.sv */
// Wait source standing in for the instruction and data memories.
// Assumes the bench raises go_i in the cycle of the request it wants held.
`timescale 1ns/1ps
module mem_stall_model (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       arst_n_i,
   // Command from the bench
   input  wire logic       go_i,
   input  wire logic       data_side_i,
   input  wire logic [3:0] len_i,
   // Wait indications toward the block
   output logic            instr_stall_o,
   output logic            data_stall_o
);
   logic [3:0] cnt;
   // Counts the remaining wait cycles after the first one.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= 4'h0;
      end else if (go_i) begin
         cnt <= len_i - 4'h1;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end
   assign data_stall_o  = data_side_i & (go_i | (cnt != 4'h0));
   assign instr_stall_o = ~data_side_i & (go_i | (cnt != 4'h0));
endmodule // mem_stall_model

/* dv/tb_instr_cycle_timing.sv */
// Self-checking bench for the per-class cycle timing block.
// Assumes the stall model as far side; counts cycles from take to done.
`timescale 1ns/1ps
module tb_instr_cycle_timing;
   localparam int ADDMUL_LAT = 4;
   logic                   mclk_i = 1'b0;
   logic                   arst_n_i = 1'b0;
   logic                   issue_valid = 1'b0;
   timing_pkg::issue_type  issue = '0;
   logic                   go = 1'b0;
   logic                   data_side = 1'b0;
   logic [3:0]             len = 4'h0;
   logic                   instr_stall;
   logic                   data_stall;
   timing_pkg::status_type status;
   timing_pkg::status_type s1;
   int                     bus;
   int                     err_count = 0;
   int                     total_checks = 0;

   always #5 mclk_i = ~mclk_i;

   instr_cycle_timing #(.fp_add_multiply_latency(ADDMUL_LAT), .fp_misc_op_latency(2)) i_instr_cycle_timing (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .issue_valid_i(issue_valid), .issue_i(issue),
      .instr_stall_i(instr_stall), .data_stall_i(data_stall), .status_o(status));
   mem_stall_model i_mem_stall_model (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .go_i(go), .data_side_i(data_side),
      .len_i(len), .instr_stall_o(instr_stall), .data_stall_o(data_stall));

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", what, e, g);
      end
   endtask

   function automatic timing_pkg::issue_type mk(input timing_pkg::iclass_type c);
      mk = '0;
      mk.iclass = c;
   endfunction

   // Issues one instruction and counts cycles until its done pulse.
   task automatic run(input timing_pkg::issue_type ins, input int exp);
      int n;
      @(posedge mclk_i);
      issue_valid <= 1'b1;
      issue <= ins;
      go <= (len != 4'h0);
      @(posedge mclk_i);
      issue_valid <= 1'b0;
      go <= 1'b0;
      #1;
      s1 = status;
      bus = int'(status.bus_txn);
      n = 1;
      while (status.done !== 1'b1 && n < 60) begin
         @(posedge mclk_i);
         #1;
         n++;
         bus += int'(status.bus_txn);
      end
      chk("cycles", 32'(exp), 32'(n));
   endtask

   task automatic t_arith;
      timing_pkg::issue_type i;
      run(mk(timing_pkg::IC_INT), 1);
      run(mk(timing_pkg::IC_MUL), 1);
      run(mk(timing_pkg::IC_MULH), 5);
      chk("ex_busy", 1, s1.ex_busy & ~s1.ready);
      i = mk(timing_pkg::IC_DIV);
      i.divisor = 32'h8000_0000;
      run(i, 3);
      i.divisor = 32'h0001_0000;
      run(i, 18);
      i.divisor = 32'h0000_0000;
      run(i, 35);
      $display("test arith done");
   endtask

   task automatic t_mem;
      timing_pkg::issue_type i;
      i = mk(timing_pkg::IC_STORE);
      i.size = timing_pkg::SZ_WORD;
      run(i, 1);
      chk("bus_txn", 1, bus);
      i.addr_lo = 2'h1;
      run(i, 2);
      chk("bus_txn", 2, bus);
      i = mk(timing_pkg::IC_LOAD);
      i.size = timing_pkg::SZ_HALF;
      i.addr_lo = 2'h3;
      run(i, 2);
      chk("bus_txn", 2, bus);
      i.addr_lo = 2'h2;
      run(i, 1);
      run(mk(timing_pkg::IC_ELW), 4);
      len = 4'h2;
      data_side = 1'b1;
      run(i, 3);
      len = 4'h0;
      data_side = 1'b0;
      $display("test memory done");
   endtask

   task automatic t_flow;
      timing_pkg::issue_type i;
      i = mk(timing_pkg::IC_JUMP);
      i.target = 32'h0000_1000;
      run(i, 2);
      chk("flush_if", 1, s1.flush_if);
      chk("flush_id", 0, s1.flush_id);
      chk("fetch_addr", 32'h0000_1000, s1.fetch_req ? s1.fetch_addr : 32'h0000_0000);
      i.target_unaligned = 1'b1;
      run(i, 3);
      i = mk(timing_pkg::IC_BRANCH);
      run(i, 1);
      chk("flush_if", 0, s1.flush_if);
      len = 4'h1;
      run(i, 2);
      len = 4'h0;
      i.taken = 1'b1;
      run(i, 3);
      chk("flush_id", 1, s1.flush_id & s1.flush_if);
      i.target_unaligned = 1'b1;
      run(i, 4);
      i = mk(timing_pkg::IC_FENCE_I);
      i.pc = 32'h0000_0100;
      run(i, 2);
      chk("fetch_addr", 32'h0000_0104, s1.fetch_addr);
      i.target_unaligned = 1'b1;
      run(i, 3);
      $display("test flow done");
   endtask

   task automatic t_csr;
      timing_pkg::issue_type i;
      logic [11:0] slow[11] = '{12'h300, 12'h305, 12'h320, 12'h323, 12'h33f, 12'h341, 12'h342, 12'h7b0,
                                12'h7b3, 12'hb00, 12'hb9f};
      logic [11:0] fast[4] = '{12'h301, 12'h340, 12'h7b4, 12'hc00};
      i = mk(timing_pkg::IC_CSR);
      foreach (slow[k]) begin
         i.csr_addr = slow[k];
         run(i, 4);
      end
      foreach (fast[k]) begin
         i.csr_addr = fast[k];
         run(i, 1);
      end
      $display("test register access done");
   endtask

   task automatic t_fp;
      timing_pkg::issue_type i;
      timing_pkg::issue_type j;
      i = mk(timing_pkg::IC_LOAD);
      i.rd = 5'h3;
      j = mk(timing_pkg::IC_INT);
      j.rs1 = 5'h3;
      run(i, 1);
      run(j, 2);
      i = mk(timing_pkg::IC_FP);
      i.rd = 5'h5;
      j.rs1 = 5'h5;
      run(i, 1);
      chk("fp_dispatch", 3, {s1.fp_dispatch, s1.fp_busy});
      run(j, ADDMUL_LAT);
      run(i, 1);
      repeat (4) run(mk(timing_pkg::IC_INT), 1);
      run(j, 1);
      i.fp_kind = timing_pkg::FP_MISC;
      run(i, 1);
      run(j, 2);
      i.fp_kind = timing_pkg::FP_DIVSQRT;
      run(i, 1);
      run(j, 11);
      $display("test floating point done");
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // A hang is cut off well beyond the few hundred cycles needed.
   initial begin
      #200000;
      err_count++;
      wrap_up;
   end

   initial begin
      repeat (20) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      t_arith;
      t_mem;
      t_flow;
      t_csr;
      t_fp;
      wrap_up;
   end
endmodule // tb_instr_cycle_timing
